// file: ebd_pkg.sv
// Purpose: Shared constants and types for the buffer DMA / checksum engine.
// Assumes: Registers are 8 bits wide, one per aligned 32-bit Avalon word.
// Notes:   Offsets are byte addresses on the register bus.

`default_nettype none

package ebd_pkg;

  // ==========================================================================
  // Engine states
  typedef enum logic [3:0] {
    EBD_IDLE = 4'h1,
    EBD_WAIT = 4'h2,
    EBD_RUN  = 4'h4,
    EBD_FIN  = 4'h8
  } ebd_state_e;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h00;
  localparam logic [7:0] OFS_IRQ_FLAGS    = 8'h04;
  localparam logic [7:0] OFS_CONTROL_ONE  = 8'h08;
  localparam logic [7:0] OFS_RX_END_LOW   = 8'h0C;
  localparam logic [7:0] OFS_RX_END_HIGH  = 8'h10;
  localparam logic [7:0] OFS_SRC_LOW      = 8'h14;
  localparam logic [7:0] OFS_SRC_HIGH     = 8'h18;
  localparam logic [7:0] OFS_END_LOW      = 8'h1C;
  localparam logic [7:0] OFS_END_HIGH     = 8'h20;
  localparam logic [7:0] OFS_TARGET_LOW   = 8'h24;
  localparam logic [7:0] OFS_TARGET_HIGH  = 8'h28;
  localparam logic [7:0] OFS_SUM_LOW      = 8'h2C;
  localparam logic [7:0] OFS_SUM_HIGH     = 8'h30;
  localparam logic [7:0] OFS_ETH_IRQ_EN   = 8'h34;
  localparam logic [7:0] OFS_RX_START_LOW = 8'h38;
  localparam logic [7:0] OFS_RX_START_HI  = 8'h3C;

  // ==========================================================================
  // Field positions
  localparam int DONE_IE_BIT  = 5;
  localparam int DONE_FLG_BIT = 5;
  localparam int GO_BIT       = 5;
  localparam int CSUM_BIT     = 4;
  localparam int TXPEND_BIT   = 3;
  localparam int ETH_IE_BIT   = 0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_SUM  = 16'h0000;

endpackage : ebd_pkg

`default_nettype wire

// file: ebd_dma_engine.sv
// Purpose: Copy and checksum DMA engine inside the 8 KB packet buffer.
// Assumes: Buffer RAM has a read port (data one cycle after bufRead) and
//          a separate write port; arbitration inputs flag foreign accesses.
// Notes:   Registers sit behind an Avalon-MM slave with one wait cycle.

`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Destination advances by one per byte, wrapping only at buffer top.
// - Go while transmit pending waits until transmission finishes.
// - Copy end clears go, sets done, keeps pointers and checksum result.
// - One byte per cycle when nobody else needs the buffer.
// - Stall in any cycle the CPU window or receive logic uses memory.
// - Checksum reads bytes as 16-bit words, earlier byte high.
// - Odd byte count is padded with a zero byte.
// - Result is inverted one's-complement sum with end-around carry.
// - Checksum end clears go, sets done, writes no memory, stores result.
// - Checksum takes one cycle per byte, apart from stalls.
// - Checksum does not begin while transmit remains pending.
// - Pointers are 13 bits, split into low byte and five-bit high byte.
// - Checksum result is 16 bits in low and high byte registers.
// - After the receive ring end byte, source reloads ring start.
// - Operation ends when the source pointer equals the end pointer.
// - Clearing go cancels at once; copied bytes stay written.
module ebd_dma_engine #(
  parameter int AW = 13
) (
  // Clock and reset
  input  wire logic          core_clk,
  input  wire logic          srst,
  // Avalon-MM register slave
  input  wire logic [7:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic      [31:0]   avs_readdata,
  output logic               avs_waitrequest,
  // Buffer memory ports
  output logic      [AW-1:0] bufRdAddr,
  output logic               bufRead,
  input  wire logic [7:0]    bufRdData,
  output logic      [AW-1:0] bufWrAddr,
  output logic      [7:0]    bufWrData,
  output logic               bufWrite,
  // Neighbouring agents
  input  wire logic          cpuWindowAccess,
  input  wire logic          rxByteStore,
  input  wire logic          txRequestPending,
  // Done interrupt request
  output logic               ethIrq
);

  // ==========================================================================
  // Parameter check
  if (AW < 9 || AW > 16) begin : g_bad_aw
    $error("AW must lie between 9 and 16");
  end

  // ==========================================================================
  // State
  typedef struct packed {
    ebd_pkg::ebd_state_e st;
    logic                ack;
    logic [31:0]         rdata;
    logic                doneIe;
    logic                ethernet_irq_enable;
    logic                doneFlag;
    logic                go;
    logic                csum;
    logic [AW-1:0]       rxEnd;
    logic [AW-1:0]       rxStart;
    logic [AW-1:0]       srcStart;
    logic [AW-1:0]       srcEnd;
    logic [AW-1:0]       dst;
    logic [15:0]         result;
    logic [AW-1:0]       src;
    logic [AW-1:0]       wrPtr;
    logic                rdDone;
    logic                inflight;
    logic [1:0]          cnt;
    logic [7:0]          q0;
    logic [7:0]          q1;
    logic [15:0]         acc;
    logic [7:0]          hiByte;
    logic                odd;
  } ebd_regs_s;

  localparam ebd_regs_s RESET_REGS = '{st: ebd_pkg::EBD_IDLE, default: '0};

  ebd_regs_s st_r;
  ebd_regs_s st_nxt;

  logic       stall;
  logic       running;
  logic       popNow;
  logic       issue;
  logic [2:0] occ;
  logic       swWr;
  logic       swRd;

  function automatic logic [15:0] onesAdd(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction : onesAdd

  // ==========================================================================
  // Arbitration and buffer strobes
  // foreign accesses win
  assign stall   = cpuWindowAccess | rxByteStore;
  assign running = (st_r.st == ebd_pkg::EBD_RUN) && st_r.go;
  assign occ     = {1'b0, st_r.cnt} + {2'b00, st_r.inflight};
  assign popNow  = running && !stall && (st_r.cnt != 2'h0);
  // one read per free cycle
  // Two-entry holding queue keeps full rate even when a stall hits mid-pipe
  assign issue   = running && !stall && !st_r.rdDone && (occ <= {2'b00, popNow} + 3'h1);

  assign bufRead   = issue;
  assign bufRdAddr = st_r.src;
  // no memory writes in checksum mode
  assign bufWrite  = popNow && !st_r.csum;
  assign bufWrAddr = st_r.wrPtr;
  assign bufWrData = st_r.q0;

  assign ethIrq = st_r.doneFlag && st_r.doneIe && st_r.ethernet_irq_enable;

  // ==========================================================================
  // Avalon slave handshake
  assign swWr            = avs_write && st_r.ack;
  assign swRd            = avs_read && !st_r.ack;
  assign avs_waitrequest = (avs_read || avs_write) && !st_r.ack;
  assign avs_readdata    = st_r.rdata;

  // ==========================================================================
  // Next state
  always_comb begin
    logic [7:0]    rdByte;
    logic [7:0]    wb;
    logic [1:0]    cntA;
    logic [7:0]    q0A;
    logic [15:0]   fin;
    rdByte = ebd_pkg::RESET_BYTE;
    wb     = avs_writedata[7:0];
    cntA   = st_r.cnt;
    q0A    = st_r.q0;
    fin    = st_r.acc;
    st_nxt = st_r;

    st_nxt.ack = (avs_read || avs_write) && !st_r.ack;

    // Register read decode
    // pointers read as low byte and upper bits
    if (avs_address == ebd_pkg::OFS_IRQ_ENABLE) begin
      rdByte[ebd_pkg::DONE_IE_BIT] = st_r.doneIe;
    end else if (avs_address == ebd_pkg::OFS_IRQ_FLAGS) begin
      rdByte[ebd_pkg::DONE_FLG_BIT] = st_r.doneFlag;
    end else if (avs_address == ebd_pkg::OFS_CONTROL_ONE) begin
      rdByte[ebd_pkg::GO_BIT]     = st_r.go;
      rdByte[ebd_pkg::CSUM_BIT]   = st_r.csum;
      rdByte[ebd_pkg::TXPEND_BIT] = txRequestPending;
    end else if (avs_address == ebd_pkg::OFS_RX_END_LOW) begin
      rdByte = st_r.rxEnd[7:0];
    end else if (avs_address == ebd_pkg::OFS_RX_END_HIGH) begin
      rdByte = 8'(st_r.rxEnd >> 8);
    end else if (avs_address == ebd_pkg::OFS_SRC_LOW) begin
      rdByte = st_r.srcStart[7:0];
    end else if (avs_address == ebd_pkg::OFS_SRC_HIGH) begin
      rdByte = 8'(st_r.srcStart >> 8);
    end else if (avs_address == ebd_pkg::OFS_END_LOW) begin
      rdByte = st_r.srcEnd[7:0];
    end else if (avs_address == ebd_pkg::OFS_END_HIGH) begin
      rdByte = 8'(st_r.srcEnd >> 8);
    end else if (avs_address == ebd_pkg::OFS_TARGET_LOW) begin
      rdByte = st_r.dst[7:0];
    end else if (avs_address == ebd_pkg::OFS_TARGET_HIGH) begin
      rdByte = 8'(st_r.dst >> 8);
    end else if (avs_address == ebd_pkg::OFS_SUM_LOW) begin
      rdByte = st_r.result[7:0];
    end else if (avs_address == ebd_pkg::OFS_SUM_HIGH) begin
      rdByte = st_r.result[15:8];
    end else if (avs_address == ebd_pkg::OFS_ETH_IRQ_EN) begin
      rdByte[ebd_pkg::ETH_IE_BIT] = st_r.ethernet_irq_enable;
    end else if (avs_address == ebd_pkg::OFS_RX_START_LOW) begin
      rdByte = st_r.rxStart[7:0];
    end else if (avs_address == ebd_pkg::OFS_RX_START_HI) begin
      rdByte = 8'(st_r.rxStart >> 8);
    end
    if (swRd) begin
      st_nxt.rdata = {24'h000000, rdByte};
    end

    // Register write decode; unmapped writes are dropped
    if (swWr && avs_byteenable[0]) begin
      if (avs_address == ebd_pkg::OFS_IRQ_ENABLE) begin
        st_nxt.doneIe = wb[ebd_pkg::DONE_IE_BIT];
      end else if (avs_address == ebd_pkg::OFS_IRQ_FLAGS) begin
        st_nxt.doneFlag = wb[ebd_pkg::DONE_FLG_BIT];
      end else if (avs_address == ebd_pkg::OFS_CONTROL_ONE) begin
        st_nxt.go   = wb[ebd_pkg::GO_BIT];
        st_nxt.csum = wb[ebd_pkg::CSUM_BIT];
      end else if (avs_address == ebd_pkg::OFS_RX_END_LOW) begin
        st_nxt.rxEnd[7:0] = wb;
      end else if (avs_address == ebd_pkg::OFS_RX_END_HIGH) begin
        st_nxt.rxEnd[AW-1:8] = wb[AW-9:0];
      end else if (avs_address == ebd_pkg::OFS_SRC_LOW) begin
        st_nxt.srcStart[7:0] = wb;
      end else if (avs_address == ebd_pkg::OFS_SRC_HIGH) begin
        st_nxt.srcStart[AW-1:8] = wb[AW-9:0];
      end else if (avs_address == ebd_pkg::OFS_END_LOW) begin
        st_nxt.srcEnd[7:0] = wb;
      end else if (avs_address == ebd_pkg::OFS_END_HIGH) begin
        st_nxt.srcEnd[AW-1:8] = wb[AW-9:0];
      end else if (avs_address == ebd_pkg::OFS_TARGET_LOW) begin
        st_nxt.dst[7:0] = wb;
      end else if (avs_address == ebd_pkg::OFS_TARGET_HIGH) begin
        st_nxt.dst[AW-1:8] = wb[AW-9:0];
      end else if (avs_address == ebd_pkg::OFS_SUM_LOW) begin
        st_nxt.result[7:0] = wb;
      end else if (avs_address == ebd_pkg::OFS_SUM_HIGH) begin
        st_nxt.result[15:8] = wb;
      end else if (avs_address == ebd_pkg::OFS_ETH_IRQ_EN) begin
        st_nxt.ethernet_irq_enable = wb[ebd_pkg::ETH_IE_BIT];
      end else if (avs_address == ebd_pkg::OFS_RX_START_LOW) begin
        st_nxt.rxStart[7:0] = wb;
      end else if (avs_address == ebd_pkg::OFS_RX_START_HI) begin
        st_nxt.rxStart[AW-1:8] = wb[AW-9:0];
      end
    end

    // Engine; runs after the software writes so hardware sets win
    case (st_r.st)
      ebd_pkg::EBD_IDLE: begin
        if (st_r.go) begin
          if (txRequestPending) begin
            st_nxt.st = ebd_pkg::EBD_WAIT;
          end else begin
            st_nxt.st = ebd_pkg::EBD_RUN;
          end
        end
        st_nxt.src      = st_r.srcStart;
        st_nxt.wrPtr    = st_r.dst;
        st_nxt.rdDone   = 1'b0;
        st_nxt.inflight = 1'b0;
        st_nxt.cnt      = 2'h0;
        st_nxt.acc      = ebd_pkg::RESET_SUM;
        st_nxt.odd      = 1'b0;
      end
      ebd_pkg::EBD_WAIT: begin
        if (!st_r.go) begin
          st_nxt.st = ebd_pkg::EBD_IDLE;
        end else if (!txRequestPending) begin
          st_nxt.st = ebd_pkg::EBD_RUN;
        end
      end
      ebd_pkg::EBD_RUN: begin
        if (!st_r.go) begin
          // cancel drops the pipeline, registers untouched
          st_nxt.st       = ebd_pkg::EBD_IDLE;
          st_nxt.inflight = 1'b0;
          st_nxt.cnt      = 2'h0;
        end else begin
          if (popNow) begin
            cntA = st_r.cnt - 2'h1;
            q0A  = st_r.q1;
            if (!st_r.csum) begin
              // linear destination, natural wrap at buffer top
              st_nxt.wrPtr = st_r.wrPtr + AW'(1);
            end else if (!st_r.odd) begin
              // earlier byte is the high half
              st_nxt.hiByte = st_r.q0;
              st_nxt.odd    = 1'b1;
            end else begin
              // second byte completes the word; add it with end-around carry
              st_nxt.acc = onesAdd(st_r.acc, {st_r.hiByte, st_r.q0});
              st_nxt.odd = 1'b0;
            end
          end
          if (st_r.inflight) begin
            if (cntA == 2'h0) begin
              q0A = bufRdData;
            end else begin
              st_nxt.q1 = bufRdData;
            end
            cntA = cntA + 2'h1;
          end
          st_nxt.q0       = q0A;
          st_nxt.cnt      = cntA;
          st_nxt.inflight = issue;
          if (issue) begin
            if (st_r.src == st_r.srcEnd) begin
              st_nxt.rdDone = 1'b1;
            end else if (st_r.src == st_r.rxEnd) begin
              st_nxt.src = st_r.rxStart;
            end else begin
              st_nxt.src = st_r.src + AW'(1);
            end
          end
          if (st_r.rdDone && !st_r.inflight && st_r.cnt == 2'h0) begin
            st_nxt.st = ebd_pkg::EBD_FIN;
          end
        end
      end
      ebd_pkg::EBD_FIN: begin
        // pad an odd tail with a zero byte
        if (st_r.odd) begin
          fin = onesAdd(st_r.acc, {st_r.hiByte, 8'h00});
        end
        // result stored only in checksum mode
        if (st_r.csum) begin
          st_nxt.result = ~fin;
        end
        // finish clears go and flags done
        st_nxt.go       = 1'b0;
        st_nxt.doneFlag = 1'b1;
        st_nxt.st       = ebd_pkg::EBD_IDLE;
      end
      default: begin
        st_nxt.st = ebd_pkg::EBD_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= RESET_REGS;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence sFinish;
    st_r.st == ebd_pkg::EBD_FIN;
  endsequence

  sequence sCancel;
    st_r.st == ebd_pkg::EBD_RUN && !st_r.go;
  endsequence

  sequence sLastRead;
    bufRead && st_r.src == st_r.srcEnd;
  endsequence

  a_stall_no_access: assert property (stall |-> !bufRead && !bufWrite)
    else $error("buffer accessed during a stall cycle");

  a_dest_linear: assert property (bufWrite |=> st_r.wrPtr == AW'($past(st_r.wrPtr) + AW'(1)))
    else $error("destination did not advance by one");

  a_tx_postpone: assert property (txRequestPending && st_r.st != ebd_pkg::EBD_RUN
                                  |=> st_r.st != ebd_pkg::EBD_RUN && !bufRead)
    else $error("engine started while transmit pending");

  a_finish_flags: assert property (sFinish |=> !st_r.go && st_r.doneFlag && st_r.st == ebd_pkg::EBD_IDLE)
    else $error("finish did not clear go and set done");

  a_copy_keeps_sum: assert property (sFinish and (!st_r.csum && !swWr) |=> $stable(st_r.result))
    else $error("copy changed the checksum result");

  a_csum_no_write: assert property (st_r.csum && st_r.st == ebd_pkg::EBD_RUN |-> !bufWrite)
    else $error("checksum mode wrote buffer memory");

  a_full_rate: assert property (running && !stall && !st_r.rdDone && st_r.cnt == 2'h0 && !st_r.inflight
                                |-> bufRead)
    else $error("idle cycle while engine free to read");

  a_ring_reload: assert property (bufRead && st_r.src != st_r.srcEnd && st_r.src == st_r.rxEnd
                                  |=> st_r.src == st_r.rxStart)
    else $error("source did not reload ring start");

  a_end_stop: assert property (sLastRead |=> !bufRead [*3])
    else $error("read issued after the end byte");

  a_cancel_now: assert property (sCancel |=> st_r.st == ebd_pkg::EBD_IDLE && !bufRead && !bufWrite)
    else $error("cancel did not stop the engine");

endmodule : ebd_dma_engine

`default_nettype wire

// file: ebd_dma_engine_tb.sv
// Purpose: Self-checking bench for the buffer DMA and checksum engine.
// Assumes: One wait cycle per register access; buffer data returns one cycle after bufRead.
// Notes:   The bench models the buffer RAM and plays the CPU, receive and transmit agents.
`timescale 1ns/1ps
`default_nettype none
module ebd_dma_engine_tb;
  // ==========================================================================
  // Signals
  logic        core_clk;
  logic        srst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [12:0] bufRdAddr;
  logic        bufRead;
  logic [7:0]  bufRdData;
  logic [12:0] bufWrAddr;
  logic [7:0]  bufWrData;
  logic        bufWrite;
  logic        cpuWindowAccess;
  logic        rxByteStore;
  logic        txRequestPending;
  logic        ethIrq;
  logic [7:0]  mem [0:8191];
  logic [12:0] wrAddrQ [$];
  int          bad_count;
  int          n_checks;
  int          rdCount;
  int          wrCount;
  int          cyc;
  int          firstRd;
  int          lastRd;
  logic [7:0]  q;

  ebd_dma_engine #(.AW(13)) uut (
    .core_clk(core_clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bufRdAddr(bufRdAddr), .bufRead(bufRead), .bufRdData(bufRdData),
    .bufWrAddr(bufWrAddr), .bufWrData(bufWrData), .bufWrite(bufWrite),
    .cpuWindowAccess(cpuWindowAccess), .rxByteStore(rxByteStore),
    .txRequestPending(txRequestPending), .ethIrq(ethIrq)
  );

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Reporting
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // ==========================================================================
  // Buffer RAM model and bus-use monitor
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (bufRead === 1'b1) begin
      bufRdData <= mem[bufRdAddr];
      rdCount <= rdCount + 1;
      if (rdCount == 0)
        firstRd <= cyc;
      lastRd <= cyc;
    end
    if (bufWrite === 1'b1) begin
      mem[bufWrAddr] <= bufWrData;
      wrAddrQ.push_back(bufWrAddr);
      wrCount <= wrCount + 1;
    end
    if (cpuWindowAccess || rxByteStore)
      chk("stalled buffer use", 16'({bufRead, bufWrite}), 16'h0000);
  end

  // ==========================================================================
  // Register bus
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    int i;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    r = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i == 20) begin
      bad_count++;
      $display("FAIL bus timeout expected 0 seen 1");
      conclude();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00, q);
  endtask : rd

  task automatic setp(input logic [7:0] lo, input logic [12:0] v);
    wr(lo, v[7:0]);
    wr(lo + 8'h04, {3'b000, v[12:8]});
  endtask : setp

  task automatic clear_counts();
    @(posedge core_clk);
    rdCount <= 0;
    wrCount <= 0;
    wrAddrQ.delete();
  endtask : clear_counts

  task automatic wait_done();
    int i;
    for (i = 0; i < 100; i++) begin
      rd(ebd_pkg::OFS_IRQ_FLAGS);
      if (q[5] === 1'b1)
        break;
    end
    if (i == 100) begin
      bad_count++;
      $display("FAIL done timeout expected 1 seen 0");
      conclude();
    end
  endtask : wait_done

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    rd(ebd_pkg::OFS_CONTROL_ONE);
    chk("control reset", 16'(q), 16'h0000);
    wr(ebd_pkg::OFS_SRC_HIGH, 8'hFF);
    rd(ebd_pkg::OFS_SRC_HIGH);
    chk("pointer high width", 16'(q), 16'h001F);
    wr(ebd_pkg::OFS_SRC_HIGH, 8'h00);
    rd(8'h40);
    chk("unmapped read", 16'(q), 16'h0000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_copy();
    mem[13'h0010] = 8'h11;
    mem[13'h0011] = 8'h22;
    mem[13'h0012] = 8'h33;
    setp(ebd_pkg::OFS_SRC_LOW, 13'h0010);
    setp(ebd_pkg::OFS_END_LOW, 13'h0012);
    setp(ebd_pkg::OFS_TARGET_LOW, 13'h1FFF);
    wr(ebd_pkg::OFS_IRQ_ENABLE, 8'h20);
    wr(ebd_pkg::OFS_ETH_IRQ_EN, 8'h01);
    wr(ebd_pkg::OFS_IRQ_FLAGS, 8'h00);
    clear_counts();
    cpuWindowAccess <= 1'b1;
    wr(ebd_pkg::OFS_CONTROL_ONE, 8'h20);
    repeat (6) @(posedge core_clk);
    chk("reads while stalled", 16'(rdCount), 16'h0000);
    cpuWindowAccess <= 1'b0;
    wait_done();
    chk("copy writes", 16'(wrCount), 16'h0003);
    chk("dest first", 16'(wrAddrQ[0]), 16'h1FFF);
    chk("dest wrap", 16'(wrAddrQ[1]), 16'h0000);
    chk("dest next", 16'(wrAddrQ[2]), 16'h0001);
    chk("byte 0", 16'(mem[13'h1FFF]), 16'h0011);
    chk("byte 2", 16'(mem[13'h0001]), 16'h0033);
    chk("read spacing", 16'(lastRd - firstRd), 16'h0002);
    chk("done irq", 16'(ethIrq), 16'h0001);
    rd(ebd_pkg::OFS_CONTROL_ONE);
    chk("go cleared", 16'(q), 16'h0000);
    rd(ebd_pkg::OFS_TARGET_HIGH);
    chk("dest kept", 16'(q), 16'h001F);
    rd(ebd_pkg::OFS_SUM_LOW);
    chk("sum kept", 16'(q), 16'h0000);
    wr(ebd_pkg::OFS_IRQ_FLAGS, 8'h00);
    rd(ebd_pkg::OFS_IRQ_FLAGS);
    chk("irq cleared", 16'(ethIrq), 16'h0000);
    $display("test copy done");
  endtask : t_copy

  task automatic t_sum();
    mem[13'h001F] = 8'h89;
    mem[13'h0020] = 8'hAB;
    mem[13'h0000] = 8'hCD;
    setp(ebd_pkg::OFS_RX_END_LOW, 13'h0020);
    setp(ebd_pkg::OFS_RX_START_LOW, 13'h0000);
    setp(ebd_pkg::OFS_SRC_LOW, 13'h001F);
    setp(ebd_pkg::OFS_END_LOW, 13'h0000);
    wr(ebd_pkg::OFS_ETH_IRQ_EN, 8'h00);
    clear_counts();
    txRequestPending <= 1'b1;
    rxByteStore <= 1'b1;
    wr(ebd_pkg::OFS_CONTROL_ONE, 8'h30);
    repeat (8) @(posedge core_clk);
    chk("held by transmit", 16'(rdCount), 16'h0000);
    rd(ebd_pkg::OFS_CONTROL_ONE);
    chk("pending visible", 16'(q), 16'h0038);
    txRequestPending <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("held by receive", 16'(rdCount), 16'h0000);
    rxByteStore <= 1'b0;
    wait_done();
    chk("sum writes none", 16'(wrCount), 16'h0000);
    chk("ring wrap reads", 16'(rdCount), 16'h0003);
    chk("sum spacing", 16'(lastRd - firstRd), 16'h0002);
    rd(ebd_pkg::OFS_SUM_LOW);
    chk("sum low", 16'(q), 16'h0053);
    rd(ebd_pkg::OFS_SUM_HIGH);
    chk("sum high", 16'(q), 16'h00A9);
    chk("irq masked", 16'(ethIrq), 16'h0000);
    rd(ebd_pkg::OFS_CONTROL_ONE);
    chk("go cleared", 16'(q), 16'h0010);
    rd(ebd_pkg::OFS_SRC_LOW);
    chk("source kept", 16'(q), 16'h001F);
    $display("test checksum done");
  endtask : t_sum

  task automatic t_cancel();
    int n;
    wr(ebd_pkg::OFS_IRQ_FLAGS, 8'h00);
    setp(ebd_pkg::OFS_SRC_LOW, 13'h0100);
    setp(ebd_pkg::OFS_END_LOW, 13'h01FF);
    setp(ebd_pkg::OFS_TARGET_LOW, 13'h0400);
    clear_counts();
    wr(ebd_pkg::OFS_CONTROL_ONE, 8'h20);
    repeat (10) @(posedge core_clk);
    wr(ebd_pkg::OFS_CONTROL_ONE, 8'h00);
    repeat (4) @(posedge core_clk);
    n = wrCount;
    repeat (20) @(posedge core_clk);
    chk("copy started", 16'(wrCount > 0), 16'h0001);
    chk("no writes after cancel", 16'(wrCount), 16'(n));
    rd(ebd_pkg::OFS_IRQ_FLAGS);
    chk("no done on cancel", 16'(q), 16'h0000);
    rd(ebd_pkg::OFS_SRC_HIGH);
    chk("source kept", 16'(q), 16'h0001);
    $display("test cancel done");
  endtask : t_cancel

  // ==========================================================================
  // Main sequence
  initial begin
    srst = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    bufRdData = 8'h00;
    cpuWindowAccess = 1'b0;
    rxByteStore = 1'b0;
    txRequestPending = 1'b0;
    bad_count = 0;
    n_checks = 0;
    rdCount = 0;
    wrCount = 0;
    cyc = 0;
    firstRd = 0;
    lastRd = 0;
    // Known fill so that a stray read never returns unknown data
    for (int i = 0; i < 8192; i++)
      mem[i] = 8'(i) ^ 8'h5A;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_copy();
    t_sum();
    t_cancel();
    conclude();
  end
endmodule : ebd_dma_engine_tb
`default_nettype wire
